// *** memory_map_decode_ports_tb.sv ***
`timescale 1ns/10ps
`default_nettype none

module memory_map_decode_ports_tb;
  localparam mmd_pkg::mmd_region_t RG = mmd_pkg::REG_PAGE;
  localparam mmd_pkg::mmd_region_t RA = mmd_pkg::RAM;
  localparam mmd_pkg::mmd_region_t CC = mmd_pkg::CAN_CTRL;
  localparam mmd_pkg::mmd_region_t CB = mmd_pkg::CAN_BUF;
  localparam mmd_pkg::mmd_region_t EE = mmd_pkg::EEPROM;
  localparam mmd_pkg::mmd_region_t RV = mmd_pkg::RESERVED;
  localparam mmd_pkg::mmd_region_t UN = mmd_pkg::UNIMPL;
  logic clk;
  logic nrst;
  mmd_pkg::mmd_bus_req_t bus_req;
  logic illegal_reset_en;
  mmd_pkg::mmd_ports_t ext_level;
  mmd_pkg::mmd_ports_t pin_in;
  mmd_pkg::mmd_ports_t pin_out;
  mmd_pkg::mmd_ports_t pin_oe_n;
  logic clock_out_pin_enable;
  logic [7:0] rdata;
  logic rdata_valid;
  mmd_pkg::mmd_decode_t sel;
  logic illegal_addr_reset;
  int n_fail;
  int tests_run;
  int cycles;
  logic [15:0] t_addr [0:31];
  mmd_pkg::mmd_region_t t_reg [0:31];

  mmd_memory_map dut (
    .clk(clk),
    .nrst(nrst),
    .bus_req(bus_req),
    .illegal_reset_en(illegal_reset_en),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n),
    .clock_out_pin_enable(clock_out_pin_enable),
    .rdata(rdata),
    .rdata_valid(rdata_valid),
    .sel(sel),
    .illegal_addr_reset(illegal_addr_reset)
  );

  mmd_pin_model pins (
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n),
    .ext_level(ext_level),
    .pin_in(pin_in)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      $display("CHECK FAILED run length expected below 3000 seen 3000");
      close_out;
    end
  end

  task automatic chk(input string name, input logic [39:0] exp, input logic [39:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One request cycle, then outputs of the answer cycle are sampled
  task automatic access(input logic [15:0] a, input logic r, input logic w, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, rd: r, wr: w, wdata: d};
    @(posedge clk);
    bus_req <= '0;
    #1;
  endtask

  task automatic wr8(input logic [15:0] a, input logic [7:0] d);
    access(a, 1'b0, 1'b1, d);
  endtask

  task automatic rd8(input logic [15:0] a, input logic [7:0] exp, input string name);
    access(a, 1'b1, 1'b0, 8'h00);
    chk(name, 40'(exp), 40'(rdata));
    chk("rdata_valid", 40'h1, 40'(rdata_valid));
  endtask

  task automatic do_reset;
    @(posedge clk);
    nrst <= 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
  endtask

  initial begin
    nrst = 1'b0;
    bus_req = '0;
    illegal_reset_en = 1'b0;
    ext_level = '0;
    n_fail = 0;
    tests_run = 0;
    cycles = 0;
    t_addr = '{16'h0000, 16'h003a, 16'h000a, 16'h000b, 16'h000e, 16'h000f, 16'h001b, 16'h0021,
               16'h002d, 16'h003b, 16'h003f, 16'h0040, 16'h033f, 16'h0340, 16'h0341, 16'h0342,
               16'h04ff, 16'h0500, 16'h051f, 16'h0520, 16'h053f, 16'h0540, 16'h057f, 16'h0580,
               16'h07ff, 16'h0800, 16'h09ff, 16'h0a00, 16'h0a01, 16'h0a02, 16'h9fff, 16'hfe1f};
    t_reg = '{RG, RG, RV, RV, RV, RV, RV, RV, RV, UN, UN, RA, RA, RV, RV, UN,
              UN, CC, CC, RV, RV, CB, CB, UN, UN, EE, EE, RV, RV, UN, UN, RG};
    do_reset;
    chk("pin_oe_n", {40{1'b1}}, pin_oe_n);
    chk("clock_out_pin_enable", 40'h0, 40'(clock_out_pin_enable));
    for (int i = 4; i < 8; i++) rd8(16'(i), 8'h00, "direction reset");
    $display("test reset_values done");

    for (int i = 4; i < 8; i++) wr8(16'(i), 8'hff);
    rd8(16'h0004, 8'hff, "port_a_direction");
    rd8(16'h0005, 8'hff, "port_b_direction");
    rd8(16'h0006, 8'h9f, "port_c_direction");
    rd8(16'h0007, 8'h3f, "port_d_direction");
    chk("clock_out_pin_enable", 40'h1, 40'(clock_out_pin_enable));
    chk("oe_n a b", 40'h0, 40'({pin_oe_n.a, pin_oe_n.b}));
    chk("oe_n c d", 40'h0, 40'({pin_oe_n.c & 8'h1f, pin_oe_n.d & 8'h3f}));
    $display("test direction_access done");

    @(posedge clk);
    ext_level.e <= 8'h3c;
    foreach (t_addr[i]) if (i < 4) wr8(16'(i), 8'he7);
    wr8(16'h0008, 8'he7);
    repeat (4) @(posedge clk);
    rd8(16'h0000, 8'he7, "port_a_data");
    rd8(16'h0001, 8'he7, "port_b_data");
    rd8(16'h0002, 8'h07, "port_c_data");
    rd8(16'h0003, 8'h27, "port_d_data");
    rd8(16'h0008, 8'h3c, "port_e_data pin view");
    chk("pin_out a e", 40'he7e7, 40'({pin_out.a, pin_out.e}));
    $display("test port_data done");

    wr8(16'h0004, 8'h0f);
    @(posedge clk);
    ext_level.a <= 8'h5a;
    repeat (4) @(posedge clk);
    rd8(16'h0000, 8'h57, "port_a mixed");
    chk("oe_n a", 40'hf0, 40'(pin_oe_n.a));
    $display("test mixed_direction done");

    do_reset;
    rd8(16'h0006, 8'h00, "port_c_direction after reset");
    wr8(16'h0004, 8'hff);
    rd8(16'h0000, 8'he7, "port_a_data kept");
    $display("test data_through_reset done");

    @(posedge clk);
    illegal_reset_en <= 1'b1;
    foreach (t_addr[i]) begin
      access(t_addr[i], t_reg[i] != RV, 1'b0, 8'h00);
      chk("region", 40'(t_reg[i]), 40'(sel.region));
      chk("illegal_addr_reset", 40'(t_reg[i] == UN), 40'(illegal_addr_reset));
    end
    access(16'hfe00, 1'b1, 1'b0, 8'h00);
    chk("sys_sel", 40'h1, 40'(sel.sys_sel));
    access(16'ha000, 1'b1, 1'b0, 8'h00);
    chk("region rom low", 40'(mmd_pkg::ROM), 40'(sel.region));
    access(16'hfe20, 1'b1, 1'b0, 8'h00);
    chk("region rom high", 40'(mmd_pkg::ROM), 40'(sel.region));
    wr8(16'h0600, 8'h55);
    chk("illegal on write", 40'h1, 40'(illegal_addr_reset));
    @(posedge clk);
    illegal_reset_en <= 1'b0;
    access(16'h003c, 1'b1, 1'b0, 8'h00);
    chk("illegal disabled", 40'h0, 40'(illegal_addr_reset));
    $display("test decode done");
    close_out;
  end
endmodule

`default_nettype wire

// *** mmd_addr_decode.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "mmd_consts.svh"

module mmd_addr_decode (
  input wire logic [15:0] addr,
  output mmd_pkg::mmd_decode_t dec
);

  function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  always_comb begin
    dec = '0;
    dec.region = mmd_pkg::ROM;
    if (in_rng(addr, `MMD_IO_LO, `MMD_IO_HI)) begin
      if (addr == `MMD_IO_RSV_A || addr == `MMD_IO_RSV_B || addr == `MMD_IO_RSV_C ||
          addr == `MMD_IO_RSV_D || addr == `MMD_IO_RSV_E || addr == `MMD_IO_RSV_F ||
          addr == `MMD_IO_RSV_G) begin
        dec.region = mmd_pkg::RESERVED;
      end else begin
        dec.region = mmd_pkg::REG_PAGE;
      end
    end else if (in_rng(addr, `MMD_UNI0_LO, `MMD_UNI0_HI)) begin
      dec.region = mmd_pkg::UNIMPL;
    end else if (in_rng(addr, `MMD_RAM_LO, `MMD_RAM_HI)) begin
      dec.region = mmd_pkg::RAM;
    end else if (in_rng(addr, `MMD_RSV0_LO, `MMD_RSV0_HI)) begin
      dec.region = mmd_pkg::RESERVED;
    end else if (in_rng(addr, `MMD_UNI1_LO, `MMD_UNI1_HI)) begin
      dec.region = mmd_pkg::UNIMPL;
    end else if (in_rng(addr, `MMD_CANC_LO, `MMD_CANC_HI)) begin
      dec.region = mmd_pkg::CAN_CTRL;
    end else if (in_rng(addr, `MMD_RSV1_LO, `MMD_RSV1_HI)) begin
      dec.region = mmd_pkg::RESERVED;
    end else if (in_rng(addr, `MMD_CANB_LO, `MMD_CANB_HI)) begin
      dec.region = mmd_pkg::CAN_BUF;
    end else if (in_rng(addr, `MMD_UNI2_LO, `MMD_UNI2_HI)) begin
      dec.region = mmd_pkg::UNIMPL;
    end else if (in_rng(addr, `MMD_EE_LO, `MMD_EE_HI)) begin
      dec.region = mmd_pkg::EEPROM;
    end else if (in_rng(addr, `MMD_RSV2_LO, `MMD_RSV2_HI)) begin
      dec.region = mmd_pkg::RESERVED;
    end else if (in_rng(addr, `MMD_UNI3_LO, `MMD_UNI3_HI)) begin
      dec.region = mmd_pkg::UNIMPL;
    end else if (in_rng(addr, `MMD_SYS_LO, `MMD_SYS_HI)) begin
      dec.region = mmd_pkg::REG_PAGE;
      dec.sys_sel = 1'b1;
    end
    // One-hot selects from the single region
    dec.reg_page_sel = (dec.region == mmd_pkg::REG_PAGE) && !dec.sys_sel;
    dec.ram_sel = dec.region == mmd_pkg::RAM;
    dec.can_ctrl_sel = dec.region == mmd_pkg::CAN_CTRL;
    dec.can_buf_sel = dec.region == mmd_pkg::CAN_BUF;
    dec.eeprom_sel = dec.region == mmd_pkg::EEPROM;
    dec.rom_sel = dec.region == mmd_pkg::ROM;
    dec.reserved_hit = dec.region == mmd_pkg::RESERVED;
    dec.unimpl_hit = dec.region == mmd_pkg::UNIMPL;
  end

endmodule
`default_nettype wire

// *** mmd_consts.svh ***
`ifndef MMD_CONSTS_SVH
`define MMD_CONSTS_SVH

// Register page offsets
`define MMD_OFS_PORT_A_DATA 16'h0000
`define MMD_OFS_PORT_B_DATA 16'h0001
`define MMD_OFS_PORT_C_DATA 16'h0002
`define MMD_OFS_PORT_D_DATA 16'h0003
`define MMD_OFS_PORT_A_DIR 16'h0004
`define MMD_OFS_PORT_B_DIR 16'h0005
`define MMD_OFS_PORT_C_DIR 16'h0006
`define MMD_OFS_PORT_D_DIR 16'h0007
`define MMD_OFS_PORT_E_DATA 16'h0008

// Region bounds
`define MMD_IO_LO 16'h0000
`define MMD_IO_HI 16'h003a
`define MMD_UNI0_LO 16'h003b
`define MMD_UNI0_HI 16'h003f
`define MMD_RAM_LO 16'h0040
`define MMD_RAM_HI 16'h033f
`define MMD_RSV0_LO 16'h0340
`define MMD_RSV0_HI 16'h0341
`define MMD_UNI1_LO 16'h0342
`define MMD_UNI1_HI 16'h04ff
`define MMD_CANC_LO 16'h0500
`define MMD_CANC_HI 16'h051f
`define MMD_RSV1_LO 16'h0520
`define MMD_RSV1_HI 16'h053f
`define MMD_CANB_LO 16'h0540
`define MMD_CANB_HI 16'h057f
`define MMD_UNI2_LO 16'h0580
`define MMD_UNI2_HI 16'h07ff
`define MMD_EE_LO 16'h0800
`define MMD_EE_HI 16'h09ff
`define MMD_RSV2_LO 16'h0a00
`define MMD_RSV2_HI 16'h0a01
`define MMD_UNI3_LO 16'h0a02
`define MMD_UNI3_HI 16'h9fff
`define MMD_SYS_LO 16'hfe00
`define MMD_SYS_HI 16'hfe1f

// Reserved holes in the register page
`define MMD_IO_RSV_A 16'h000a
`define MMD_IO_RSV_B 16'h000b
`define MMD_IO_RSV_C 16'h000e
`define MMD_IO_RSV_D 16'h000f
`define MMD_IO_RSV_E 16'h001b
`define MMD_IO_RSV_F 16'h0021
`define MMD_IO_RSV_G 16'h002d

// Field masks and reset values
`define MMD_PORT_C_MASK 8'h1f
`define MMD_PORT_D_MASK 8'h3f
`define MMD_DIR_C_MASK 8'h9f
`define MMD_DIR_D_MASK 8'h3f
`define MMD_CLK_OUT_BIT 7
`define MMD_DIR_RESET 8'h00

`endif

// *** mmd_memory_map.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "mmd_consts.svh"

module mmd_memory_map (
  input wire logic clk,
  input wire logic nrst,
  input wire mmd_pkg::mmd_bus_req_t bus_req,
  input wire logic illegal_reset_en,
  input wire mmd_pkg::mmd_ports_t pin_in,
  output mmd_pkg::mmd_ports_t pin_out,
  output mmd_pkg::mmd_ports_t pin_oe_n,
  output logic clock_out_pin_enable,
  output logic [7:0] rdata,
  output logic rdata_valid,
  output mmd_pkg::mmd_decode_t sel,
  output logic illegal_addr_reset
);

  typedef struct packed {
    mmd_pkg::mmd_dirs_t dir;
    mmd_pkg::mmd_ports_t pin_out;
    mmd_pkg::mmd_ports_t oe_n;
    logic clk_out_en;
    logic [7:0] rdata;
    logic rdata_valid;
    mmd_pkg::mmd_decode_t sel;
    logic illegal;
  } mmd_state_t;

  mmd_state_t st_q;
  mmd_state_t st_d;
  mmd_pkg::mmd_ports_t data_q;
  mmd_pkg::mmd_ports_t data_d;
  mmd_pkg::mmd_decode_t dec;
  mmd_pkg::mmd_ports_t pins_s;
  logic [39:0] pins_flat;
  logic [39:0] pins_sync_flat;

  mmd_addr_decode u_dec (
    .addr(bus_req.addr),
    .dec(dec)
  );

  assign pins_flat = pin_in;

  mmd_pin_sync #(.W(40)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .pin_in(pins_flat),
    .pin_sync(pins_sync_flat)
  );

  assign pins_s = pins_sync_flat;

  // Pin readback: output bits return latch, input bits return the pin
  function automatic logic [7:0] port_view(input logic [7:0] dat, input logic [7:0] dir,
                                           input logic [7:0] pin);
    port_view = (dat & dir) | (pin & ~dir);
  endfunction

  logic acc;
  // Port E direction lives outside this block, so its pins stay inputs
  localparam logic [7:0] dir_e_full = 8'h00;

  assign acc = bus_req.rd | bus_req.wr;

  always_comb begin
    st_d = st_q;
    data_d = data_q;
    st_d.rdata_valid = 1'b0;
    st_d.illegal = 1'b0;
    st_d.sel = dec;
    if (bus_req.wr && dec.reg_page_sel) begin
      case (bus_req.addr)
        `MMD_OFS_PORT_A_DATA: data_d.a = bus_req.wdata;
        `MMD_OFS_PORT_B_DATA: data_d.b = bus_req.wdata;
        `MMD_OFS_PORT_C_DATA: data_d.c = bus_req.wdata & `MMD_PORT_C_MASK;
        `MMD_OFS_PORT_D_DATA: data_d.d = bus_req.wdata & `MMD_PORT_D_MASK;
        `MMD_OFS_PORT_A_DIR: st_d.dir.a = bus_req.wdata;
        `MMD_OFS_PORT_B_DIR: st_d.dir.b = bus_req.wdata;
        `MMD_OFS_PORT_C_DIR: st_d.dir.c = bus_req.wdata & `MMD_DIR_C_MASK;
        `MMD_OFS_PORT_D_DIR: st_d.dir.d = bus_req.wdata & `MMD_DIR_D_MASK;
        `MMD_OFS_PORT_E_DATA: data_d.e = bus_req.wdata;
        default: data_d = data_q;
      endcase
    end
    if (bus_req.rd) begin
      st_d.rdata_valid = 1'b1;
      st_d.rdata = 8'h00;
      if (dec.reg_page_sel) begin
        case (bus_req.addr)
          `MMD_OFS_PORT_A_DATA: st_d.rdata = port_view(data_q.a, st_q.dir.a, pins_s.a);
          `MMD_OFS_PORT_B_DATA: st_d.rdata = port_view(data_q.b, st_q.dir.b, pins_s.b);
          `MMD_OFS_PORT_C_DATA: st_d.rdata = port_view(data_q.c, st_q.dir.c, pins_s.c)
                                             & `MMD_PORT_C_MASK;
          `MMD_OFS_PORT_D_DATA: st_d.rdata = port_view(data_q.d, st_q.dir.d, pins_s.d)
                                             & `MMD_PORT_D_MASK;
          `MMD_OFS_PORT_A_DIR: st_d.rdata = st_q.dir.a;
          `MMD_OFS_PORT_B_DIR: st_d.rdata = st_q.dir.b;
          `MMD_OFS_PORT_C_DIR: st_d.rdata = st_q.dir.c;
          `MMD_OFS_PORT_D_DIR: st_d.rdata = st_q.dir.d;
          `MMD_OFS_PORT_E_DATA: st_d.rdata = port_view(data_q.e, dir_e_full, pins_s.e);
          default: st_d.rdata = 8'h00;
        endcase
      end
    end
    // Reserved hits get no defined answer beyond zero read data
    st_d.illegal = acc && dec.unimpl_hit && illegal_reset_en;
    // Pins: output where direction set, except port C bit 7, which sets clock_out_pin_enable instead
    st_d.pin_out = data_d;
    st_d.oe_n.a = ~st_d.dir.a;
    st_d.oe_n.b = ~st_d.dir.b;
    st_d.oe_n.c = ~(st_d.dir.c & `MMD_PORT_C_MASK);
    st_d.oe_n.d = ~(st_d.dir.d & `MMD_PORT_D_MASK);
    st_d.oe_n.e = 8'hff;
    st_d.clk_out_en = st_d.dir.c[`MMD_CLK_OUT_BIT];
  end

  // Data latches have no reset
  always_ff @(posedge clk) begin
    data_q <= data_d;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q.dir <= '0;
      st_q.pin_out <= '0;
      st_q.oe_n <= '1;
      st_q.clk_out_en <= 1'b0;
      st_q.rdata <= 8'h00;
      st_q.rdata_valid <= 1'b0;
      st_q.sel <= '0;
      st_q.illegal <= 1'b0;
    end else begin
      st_q.dir <= st_d.dir;
      st_q.pin_out <= st_d.pin_out;
      st_q.oe_n <= st_d.oe_n;
      st_q.clk_out_en <= st_d.clk_out_en;
      st_q.rdata <= st_d.rdata;
      st_q.rdata_valid <= st_d.rdata_valid;
      st_q.sel <= st_d.sel;
      st_q.illegal <= st_d.illegal;
    end
  end

  assign pin_out = st_q.pin_out;
  assign pin_oe_n = st_q.oe_n;
  assign clock_out_pin_enable = st_q.clk_out_en;
  assign rdata = st_q.rdata;
  assign rdata_valid = st_q.rdata_valid;
  assign sel = st_q.sel;
  assign illegal_addr_reset = st_q.illegal;

  property p_illegal_reset;
    @(posedge clk) disable iff (!nrst)
    (acc && dec.unimpl_hit && illegal_reset_en) |=> illegal_addr_reset;
  endproperty
  a_illegal_reset: assert property (p_illegal_reset) else $error("missing illegal reset");

  property p_no_reset_disabled;
    @(posedge clk) disable iff (!nrst)
    !illegal_reset_en |=> !illegal_addr_reset;
  endproperty
  a_no_reset_disabled: assert property (p_no_reset_disabled) else $error("reset while disabled");

  property p_ram_region;
    @(posedge clk) disable iff (!nrst)
    (bus_req.addr >= `MMD_RAM_LO && bus_req.addr <= `MMD_RAM_HI) |=> sel.ram_sel;
  endproperty
  a_ram_region: assert property (p_ram_region) else $error("ram decode wrong");

  property p_io_hole;
    @(posedge clk) disable iff (!nrst)
    (bus_req.addr == `MMD_IO_RSV_F) |=> sel.reserved_hit && !sel.reg_page_sel;
  endproperty
  a_io_hole: assert property (p_io_hole) else $error("io hole not reserved");

  property p_eeprom;
    @(posedge clk) disable iff (!nrst)
    (bus_req.addr >= `MMD_EE_LO && bus_req.addr <= `MMD_EE_HI) |=> sel.eeprom_sel;
  endproperty
  a_eeprom: assert property (p_eeprom) else $error("eeprom decode wrong");

  property p_can_buf;
    @(posedge clk) disable iff (!nrst)
    (bus_req.addr >= `MMD_CANB_LO && bus_req.addr <= `MMD_CANB_HI) |=> sel.can_buf_sel;
  endproperty
  a_can_buf: assert property (p_can_buf) else $error("can buffer decode wrong");

  property p_port_c_read;
    @(posedge clk) disable iff (!nrst)
    (bus_req.rd && bus_req.addr == `MMD_OFS_PORT_C_DATA) |=> rdata[7:5] == 3'h0;
  endproperty
  a_port_c_read: assert property (p_port_c_read) else $error("port c upper bits set");

  property p_port_d_dir;
    @(posedge clk) disable iff (!nrst)
    (bus_req.wr && bus_req.addr == `MMD_OFS_PORT_D_DIR) |=> ##1 pin_oe_n.d[7:6] == 2'h3;
  endproperty
  a_port_d_dir: assert property (p_port_d_dir) else $error("port d upper driven");

  property p_dir_a_write;
    @(posedge clk) disable iff (!nrst)
    (bus_req.wr && bus_req.addr == `MMD_OFS_PORT_A_DIR) |=> pin_oe_n.a == ~$past(bus_req.wdata);
  endproperty
  a_dir_a_write: assert property (p_dir_a_write) else $error("port a direction wrong");

  property p_sys_bank;
    @(posedge clk) disable iff (!nrst)
    (bus_req.addr >= `MMD_SYS_LO && bus_req.addr <= `MMD_SYS_HI) |=> sel.sys_sel && !sel.reg_page_sel;
  endproperty
  a_sys_bank: assert property (p_sys_bank) else $error("system bank decode wrong");

  property p_one_region;
    @(posedge clk) disable iff (!nrst)
    nrst |=> $onehot({sel.reg_page_sel, sel.ram_sel, sel.can_ctrl_sel, sel.can_buf_sel, sel.eeprom_sel,
                      sel.rom_sel, sel.sys_sel, sel.reserved_hit, sel.unimpl_hit});
  endproperty
  a_one_region: assert property (p_one_region) else $error("region select not one-hot");

  property p_unimpl_low;
    @(posedge clk) disable iff (!nrst)
    (bus_req.addr >= `MMD_UNI0_LO && bus_req.addr <= `MMD_UNI0_HI) |=> sel.unimpl_hit;
  endproperty
  a_unimpl_low: assert property (p_unimpl_low) else $error("low gap not unimplemented");

  property p_rsv_after_ram;
    @(posedge clk) disable iff (!nrst)
    (bus_req.addr >= `MMD_RSV0_LO && bus_req.addr <= `MMD_RSV0_HI) |=> sel.reserved_hit;
  endproperty
  a_rsv_after_ram: assert property (p_rsv_after_ram) else $error("bytes after ram not reserved");

  property p_unimpl_mid;
    @(posedge clk) disable iff (!nrst)
    (bus_req.addr >= `MMD_UNI1_LO && bus_req.addr <= `MMD_UNI1_HI) |=> sel.unimpl_hit;
  endproperty
  a_unimpl_mid: assert property (p_unimpl_mid) else $error("gap below can not unimplemented");

  property p_can_ctrl;
    @(posedge clk) disable iff (!nrst)
    (bus_req.addr >= `MMD_CANC_LO && bus_req.addr <= `MMD_CANC_HI) |=> sel.can_ctrl_sel;
  endproperty
  a_can_ctrl: assert property (p_can_ctrl) else $error("can control decode wrong");

  property p_rsv_can;
    @(posedge clk) disable iff (!nrst)
    (bus_req.addr >= `MMD_RSV1_LO && bus_req.addr <= `MMD_RSV1_HI) |=> sel.reserved_hit;
  endproperty
  a_rsv_can: assert property (p_rsv_can) else $error("can gap not reserved");

  property p_unimpl_can;
    @(posedge clk) disable iff (!nrst)
    (bus_req.addr >= `MMD_UNI2_LO && bus_req.addr <= `MMD_UNI2_HI) |=> sel.unimpl_hit;
  endproperty
  a_unimpl_can: assert property (p_unimpl_can) else $error("gap above can not unimplemented");

  property p_rsv_ee;
    @(posedge clk) disable iff (!nrst)
    (bus_req.addr >= `MMD_RSV2_LO && bus_req.addr <= `MMD_RSV2_HI) |=> sel.reserved_hit;
  endproperty
  a_rsv_ee: assert property (p_rsv_ee) else $error("bytes after eeprom not reserved");

  property p_unimpl_high;
    @(posedge clk) disable iff (!nrst)
    (bus_req.addr >= `MMD_UNI3_LO && bus_req.addr <= `MMD_UNI3_HI) |=> sel.unimpl_hit;
  endproperty
  a_unimpl_high: assert property (p_unimpl_high) else $error("upper gap not unimplemented");

  property p_port_e_page;
    @(posedge clk) disable iff (!nrst)
    (bus_req.addr == `MMD_OFS_PORT_E_DATA) |=> sel.reg_page_sel;
  endproperty
  a_port_e_page: assert property (p_port_e_page) else $error("port e not in register page");

  property p_reserved_quiet;
    @(posedge clk) disable iff (!nrst)
    (acc && dec.reserved_hit) |=> !illegal_addr_reset;
  endproperty
  a_reserved_quiet: assert property (p_reserved_quiet) else $error("reserved access raised reset");

  property p_illegal_cause;
    @(posedge clk) disable iff (!nrst)
    !(acc && dec.unimpl_hit) |=> !illegal_addr_reset;
  endproperty
  a_illegal_cause: assert property (p_illegal_cause) else $error("reset without unimplemented access");

  property p_port_d_read;
    @(posedge clk) disable iff (!nrst)
    (bus_req.rd && bus_req.addr == `MMD_OFS_PORT_D_DATA) |=> rdata[7:6] == 2'h0;
  endproperty
  a_port_d_read: assert property (p_port_d_read) else $error("port d upper bits set");

  property p_dir_c_read;
    @(posedge clk) disable iff (!nrst)
    (bus_req.rd && bus_req.addr == `MMD_OFS_PORT_C_DIR) |=> rdata[6:5] == 2'h0;
  endproperty
  a_dir_c_read: assert property (p_dir_c_read) else $error("port c direction gap bits set");

  property p_dir_d_read;
    @(posedge clk) disable iff (!nrst)
    (bus_req.rd && bus_req.addr == `MMD_OFS_PORT_D_DIR) |=> rdata[7:6] == 2'h0;
  endproperty
  a_dir_d_read: assert property (p_dir_d_read) else $error("port d direction upper bits set");

  property p_clk_out_en;
    @(posedge clk) disable iff (!nrst)
    (bus_req.wr && bus_req.addr == `MMD_OFS_PORT_C_DIR) |=> clock_out_pin_enable == $past(bus_req.wdata[7]);
  endproperty
  a_clk_out_en: assert property (p_clk_out_en) else $error("clock out enable wrong");

  property p_dir_c_write;
    @(posedge clk) disable iff (!nrst)
    (bus_req.wr && bus_req.addr == `MMD_OFS_PORT_C_DIR) |=> pin_oe_n.c[4:0] == ~$past(bus_req.wdata[4:0]);
  endproperty
  a_dir_c_write: assert property (p_dir_c_write) else $error("port c direction wrong");

  property p_port_c_oe;
    @(posedge clk) disable iff (!nrst)
    (bus_req.wr && bus_req.addr == `MMD_OFS_PORT_C_DIR) |=> pin_oe_n.c[7:5] == 3'h7;
  endproperty
  a_port_c_oe: assert property (p_port_c_oe) else $error("port c upper pins driven");

  property p_dir_b_write;
    @(posedge clk) disable iff (!nrst)
    (bus_req.wr && bus_req.addr == `MMD_OFS_PORT_B_DIR) |=> pin_oe_n.b == ~$past(bus_req.wdata);
  endproperty
  a_dir_b_write: assert property (p_dir_b_write) else $error("port b direction wrong");

  property p_port_e_write;
    @(posedge clk) disable iff (!nrst)
    (bus_req.wr && bus_req.addr == `MMD_OFS_PORT_E_DATA) |=> pin_out.e == $past(bus_req.wdata);
  endproperty
  a_port_e_write: assert property (p_port_e_write) else $error("port e latch wrong");

  property p_port_a_write;
    @(posedge clk) disable iff (!nrst)
    (bus_req.wr && bus_req.addr == `MMD_OFS_PORT_A_DATA) |=> pin_out.a == $past(bus_req.wdata);
  endproperty
  a_port_a_write: assert property (p_port_a_write) else $error("port a latch wrong");

endmodule
`default_nettype wire

// *** mmd_pin_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module mmd_pin_model (
  input wire mmd_pkg::mmd_ports_t pin_out,
  input wire mmd_pkg::mmd_ports_t pin_oe_n,
  input wire mmd_pkg::mmd_ports_t ext_level,
  output mmd_pkg::mmd_ports_t pin_in
);
  // Driven bits follow the block, released bits follow the outside source
  assign pin_in = mmd_pkg::mmd_ports_t'((pin_out & ~pin_oe_n) | (ext_level & pin_oe_n));
endmodule

`default_nettype wire

// *** mmd_pin_sync.sv ***
`timescale 1ns/10ps
`default_nettype none

module mmd_pin_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_sync
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } mmd_sync_state_t;

  mmd_sync_state_t st_q;
  mmd_sync_state_t st_d;

  always_comb begin
    st_d.meta = pin_in;
    st_d.sync = st_q.meta;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pin_sync = st_q.sync;

endmodule
`default_nettype wire

// *** mmd_pkg.sv ***
package mmd_pkg;

  typedef enum logic [2:0] {
    REG_PAGE,
    RAM,
    CAN_CTRL,
    CAN_BUF,
    EEPROM,
    ROM,
    RESERVED,
    UNIMPL
  } mmd_region_t;

  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } mmd_bus_req_t;

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] c;
    logic [7:0] d;
    logic [7:0] e;
  } mmd_ports_t;

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] c;
    logic [7:0] d;
  } mmd_dirs_t;

  typedef struct packed {
    mmd_region_t region;
    logic reg_page_sel;
    logic ram_sel;
    logic can_ctrl_sel;
    logic can_buf_sel;
    logic eeprom_sel;
    logic rom_sel;
    logic sys_sel;
    logic reserved_hit;
    logic unimpl_hit;
  } mmd_decode_t;

endpackage
